/* File: hdl/ccs_channel.v */
// Capture/compare/PWM channel: source select, value bytes and an AXI4-Lite slave.
// Assumes a 16-bit timer on clk_sys and external event sources on pins or other clocks.
//
// Notes on behaviour
// [R1] The 3-bit capture source field picks pin, comparator one, two, oscillator, pin change, cell one or two; 111 is reserved.
// [R2] The source select register keeps only its low three bits; bits 7 to 3 read zero.
// [R3] In capture mode each selected event loads the low value byte from the timer low byte.
// [R4] In capture mode each selected event loads the high value byte from the timer high byte.
// [R5] In compare mode the low value byte is the compare value's low byte against timer low.
// [R6] In compare mode the high value byte is the compare value's high byte against timer high.
// [R7] In right-aligned PWM, width bits 7 to 0 come from the whole low value byte.
// [R8] In right-aligned PWM, width bits 9 and 8 come from high byte bits 1 and 0; the rest is ignored.
// [R9] In left-aligned PWM, width bits 1 and 0 come from low byte bits 7 and 6; the rest is ignored.
// [R10] In left-aligned PWM, width bits 9 to 2 come from the whole high value byte.
// [R11] Any reset returns the channel registers other than the value bytes to reset values and releases the pin to input.
// [R12] A capture updates both value bytes from one timer sample in the same cycle.
// [R13] The value bytes stay software readable and writable in every mode and are not reset.
`default_nettype none
`include "ccs_map.vh"

module ccs_channel
(
   input  wire        clk_sys,
   input  wire        rst_n,
   // AXI4-Lite slave
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Timer and event sources
   input  wire [7:0]  timer_one_low_byte,
   input  wire [7:0]  timer_one_high_byte,
   input  wire        channel_mapped_pin,
   input  wire        comparator_one_output,
   input  wire        comparator_two_output,
   input  wire        numeric_oscillator_output,
   input  wire        pin_change_event,
   input  wire        logic_cell_one_out,
   input  wire        logic_cell_two_out,
   // Towards mode engine, PWM timer and pin
   output reg  [9:0]  pulse_width_value,
   output reg  [15:0] compare_value,
   output reg         compare_match,
   output reg         capture_strobe,
   output reg         pin_output_enable,
   output reg         irq
);

   // ************************************************************
   // Register state
   // ************************************************************
   reg  [7:0]  control_q;
   reg  [2:0]  source_q;
   reg  [7:0]  value_low_q;
   reg  [7:0]  value_high_q;
   reg  [2:0]  irq_status_q;
   reg  [2:0]  irq_enable_q;
   reg         src_level_q;
   reg  [4:0]  aw_addr_q;
   reg         aw_have_q;
   reg  [7:0]  w_data_q;
   reg         w_have_q;
   reg         w_lane0_q;
   reg  [7:0]  rd_byte;
   reg         rd_hit;
   reg         src_raw;
   reg         capture_hit;
   wire [6:0]  src_sync;
   wire        enabled;
   wire [3:0]  mode;
   wire        fmt;
   wire        in_capture;
   wire        in_compare;
   wire        in_pwm;
   wire        wr_fire;
   wire        wr_low;
   wire        wr_high;
   wire [9:0]  width_d;
   wire        match_d;
   wire [2:0]  irq_set;

   assign enabled    = control_q[`CCS_CTL_ENABLE_BIT];
   assign mode       = control_q[`CCS_CTL_MODE_HI:`CCS_CTL_MODE_LO];
   assign fmt        = control_q[`CCS_CTL_FMT_BIT];
   assign in_capture = enabled && (mode >= `CCS_MODE_CAP_LO) && (mode <= `CCS_MODE_CAP_HI);
   assign in_compare = enabled && (((mode >= `CCS_MODE_CMP_LO) && (mode <= `CCS_MODE_CMP_HI))
                       || (mode == 4'h1) || (mode == 4'h2));
   assign in_pwm     = enabled && (mode == `CCS_MODE_PWM);

   // ************************************************************
   // Event source synchronisers
   // ************************************************************
   ccs_sync2 u_sync0 (.clk_sys(clk_sys), .rst_n(rst_n), .din(channel_mapped_pin),
                      .dout(src_sync[0]));
   ccs_sync2 u_sync1 (.clk_sys(clk_sys), .rst_n(rst_n), .din(comparator_one_output),
                      .dout(src_sync[1]));
   ccs_sync2 u_sync2 (.clk_sys(clk_sys), .rst_n(rst_n), .din(comparator_two_output),
                      .dout(src_sync[2]));
   ccs_sync2 u_sync3 (.clk_sys(clk_sys), .rst_n(rst_n), .din(numeric_oscillator_output),
                      .dout(src_sync[3]));
   ccs_sync2 u_sync4 (.clk_sys(clk_sys), .rst_n(rst_n), .din(pin_change_event),
                      .dout(src_sync[4]));
   ccs_sync2 u_sync5 (.clk_sys(clk_sys), .rst_n(rst_n), .din(logic_cell_one_out),
                      .dout(src_sync[5]));
   ccs_sync2 u_sync6 (.clk_sys(clk_sys), .rst_n(rst_n), .din(logic_cell_two_out),
                      .dout(src_sync[6]));

   // Source multiplexer; the reserved code selects nothing
   always @*
   begin
      case (source_q)
         3'h0:    src_raw = src_sync[0]; // [R1]
         3'h1:    src_raw = src_sync[1]; // [R1]
         3'h2:    src_raw = src_sync[2]; // [R1]
         3'h3:    src_raw = src_sync[3]; // [R1]
         3'h4:    src_raw = src_sync[4]; // [R1]
         3'h5:    src_raw = src_sync[5]; // [R1]
         3'h6:    src_raw = src_sync[6]; // [R1]
         default: src_raw = 1'b0;        // [R1]
      endcase
   end

   // Capture edge decode per capture mode code
   always @*
   begin
      case (mode)
         4'h3:    capture_hit = src_raw && !src_level_q;
         4'h4:    capture_hit = !src_raw && src_level_q;
         4'h5:    capture_hit = src_raw && !src_level_q;
         4'h6:    capture_hit = src_raw && !src_level_q;
         4'h7:    capture_hit = src_raw && !src_level_q;
         default: capture_hit = 1'b0;
      endcase
      capture_hit = capture_hit && in_capture;
   end

   // ************************************************************
   // Pulse width and compare
   // ************************************************************
   // Alignment picks which bits of the value bytes form the width
   assign width_d = fmt ? {value_high_q, value_low_q[7:6]}       // [R9] [R10]
                        : {value_high_q[1:0], value_low_q};      // [R7] [R8]
   assign match_d = in_compare && (timer_one_low_byte == value_low_q)  // [R5]
                    && (timer_one_high_byte == value_high_q);          // [R6]
   assign irq_set = {in_pwm && (width_d == 10'h000), match_d && !compare_match, capture_hit};

   // ************************************************************
   // Bus write path
   // ************************************************************
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_low  = wr_fire && w_lane0_q && (aw_addr_q == `CCS_OFF_VALUE_LOW);
   assign wr_high = wr_fire && w_lane0_q && (aw_addr_q == `CCS_OFF_VALUE_HIGH);

   // Address and data are latched independently so either may come first
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         aw_addr_q     <= 5'h00;
         aw_have_q     <= 1'b0;
         w_data_q      <= 8'h00;
         w_lane0_q     <= 1'b0;
         w_have_q      <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'h0;
      end
      else
      begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr_q <= {s_axi_awaddr[4:2], 2'b00};
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data_q  <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
            w_have_q  <= 1'b1;
         end
         if (wr_fire)
         begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (aw_addr_q)
               `CCS_OFF_CONTROL, `CCS_OFF_SOURCE, `CCS_OFF_VALUE_LOW, `CCS_OFF_VALUE_HIGH,
               `CCS_OFF_IRQ_STATUS, `CCS_OFF_IRQ_ENABLE, `CCS_OFF_IRQ_CLEAR:
                  s_axi_bresp <= 2'h0;
               default:
                  s_axi_bresp <= 2'h2;
            endcase
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Control, source select, interrupt registers; set beats clear
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         control_q    <= `CCS_CTL_RESET;   // [R11]
         source_q     <= `CCS_SRC_RESET;   // [R11]
         irq_status_q <= 3'h0;
         irq_enable_q <= 3'h0;
         src_level_q  <= 1'b0;
      end
      else
      begin
         src_level_q <= src_raw;
         if (wr_fire && w_lane0_q && (aw_addr_q == `CCS_OFF_CONTROL))
            control_q <= (w_data_q & `CCS_CTL_WMASK) | (control_q & ~`CCS_CTL_WMASK);
         if (wr_fire && w_lane0_q && (aw_addr_q == `CCS_OFF_SOURCE))
            source_q <= w_data_q[2:0];     // [R2]
         if (wr_fire && w_lane0_q && (aw_addr_q == `CCS_OFF_IRQ_ENABLE))
            irq_enable_q <= w_data_q[2:0];
         if (wr_fire && w_lane0_q && (aw_addr_q == `CCS_OFF_IRQ_CLEAR))
            irq_status_q <= (irq_status_q & ~w_data_q[2:0]) | irq_set;
         else
            irq_status_q <= irq_status_q | irq_set;
         control_q[`CCS_CTL_OUT_BIT] <= compare_match;
      end
   end

   // Value bytes: no reset, capture wins over a same-cycle software write
   always @(posedge clk_sys)
   begin
      if (capture_hit)
      begin
         value_low_q  <= timer_one_low_byte;   // [R3] [R12]
         value_high_q <= timer_one_high_byte;  // [R4] [R12]
      end
      else
      begin
         if (wr_low)
            value_low_q <= w_data_q;           // [R13]
         if (wr_high)
            value_high_q <= w_data_q;          // [R13]
      end
   end

   // ************************************************************
   // Bus read path
   // ************************************************************
   always @*
   begin
      rd_hit = 1'b1;
      case ({s_axi_araddr[4:2], 2'b00})
         `CCS_OFF_CONTROL:    rd_byte = control_q;
         `CCS_OFF_SOURCE:     rd_byte = {5'h00, source_q};   // [R2]
         `CCS_OFF_VALUE_LOW:  rd_byte = value_low_q;         // [R13]
         `CCS_OFF_VALUE_HIGH: rd_byte = value_high_q;        // [R13]
         `CCS_OFF_IRQ_STATUS: rd_byte = {5'h00, irq_status_q};
         `CCS_OFF_IRQ_ENABLE: rd_byte = {5'h00, irq_enable_q};
         `CCS_OFF_IRQ_CLEAR:  rd_byte = 8'h00;
         default:
         begin
            rd_byte = 8'h00;
            rd_hit  = 1'b0;
         end
      endcase
   end

   // One read answered per handshake, rdata held until taken
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'h0;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Outputs to the mode engine
   // ************************************************************
   // Registered so every port comes from a flip-flop; pin is input under reset
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pulse_width_value <= 10'h000;
         compare_value     <= 16'h0000;
         compare_match     <= 1'b0;
         capture_strobe    <= 1'b0;
         pin_output_enable <= 1'b0;        // [R11]
         irq               <= 1'b0;
      end
      else
      begin
         pulse_width_value <= in_pwm ? width_d : 10'h000;
         compare_value     <= {value_high_q, value_low_q};  // [R5] [R6]
         compare_match     <= match_d;
         capture_strobe    <= capture_hit;
         pin_output_enable <= in_compare || in_pwm;
         irq               <= |(irq_status_q & irq_enable_q);
      end
   end

endmodule // ccs_channel
`default_nettype wire

/* File: hdl/ccs_map.vh */
// Register offsets, field positions, reset values and mode codes of the capture channel.
// Assumes inclusion by bare name from the design files.
`ifndef CCS_MAP_VH
`define CCS_MAP_VH

// ************************************************************
// Register byte offsets on the register bus
// ************************************************************
`define CCS_OFF_CONTROL    5'h00
`define CCS_OFF_SOURCE     5'h04
`define CCS_OFF_VALUE_LOW  5'h08
`define CCS_OFF_VALUE_HIGH 5'h0c
`define CCS_OFF_IRQ_STATUS 5'h10
`define CCS_OFF_IRQ_ENABLE 5'h14
`define CCS_OFF_IRQ_CLEAR  5'h18

// ************************************************************
// Control fields
// ************************************************************
`define CCS_CTL_ENABLE_BIT 7
`define CCS_CTL_OUT_BIT    5
`define CCS_CTL_FMT_BIT    4
`define CCS_CTL_MODE_HI    3
`define CCS_CTL_MODE_LO    0
`define CCS_CTL_WMASK      8'h9f
`define CCS_CTL_RESET      8'h00
`define CCS_SRC_RESET      3'h0

// ************************************************************
// Mode codes
// ************************************************************
`define CCS_MODE_OFF       4'h0
`define CCS_MODE_PWM       4'hf
`define CCS_MODE_CAP_LO    4'h3
`define CCS_MODE_CAP_HI    4'h7
`define CCS_MODE_CMP_LO    4'h8
`define CCS_MODE_CMP_HI    4'hb
`define CCS_SRC_RESERVED   3'h7

// ************************************************************
// Interrupt status bits
// ************************************************************
`define CCS_IRQ_CAPTURE    0
`define CCS_IRQ_MATCH      1
`define CCS_IRQ_WIDTH      2

`endif

/* File: hdl/ccs_sync2.v */
// Two-stage synchroniser for one asynchronous level.
// Assumes the input is a pin or an edge from an unrelated source.
`default_nettype none

module ccs_sync2
(
   input  wire clk_sys,
   input  wire rst_n,
   input  wire din,
   output reg  dout
);

   reg meta_q;

   // First stage is read only by the second stage
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule // ccs_sync2
`default_nettype wire

/* File: sim/ccs_channel_monitor.sv */
// Checker for the capture channel, bound onto its ports.
// Assumes reads go one at a time, so the last accepted address names the data returned.
`default_nettype none

// ************************************************************
// Port checker
// ************************************************************
module ccs_channel_monitor
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [4:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic [7:0]  timer_one_low_byte,
   input wire logic [7:0]  timer_one_high_byte,
   input wire logic [9:0]  pulse_width_value,
   input wire logic [15:0] compare_value,
   input wire logic        compare_match,
   input wire logic        capture_strobe,
   input wire logic        pin_output_enable,
   input wire logic        irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [4:0] rd_addr_q;

   // Address of the read in flight
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) rd_addr_q <= 5'h00;
      else if (s_axi_arvalid && s_axi_arready) rd_addr_q <= s_axi_araddr;

   property p_rst_quiet;
      $rose(rst_n) |-> !pin_output_enable && !irq && !capture_strobe;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active right after reset");
   property p_src_hi;
      s_axi_rvalid && rd_addr_q == 5'h04 |-> s_axi_rdata[31:3] == 29'h0;
   endproperty
   a_src_hi: assert property (p_src_hi)
      else $error("source select upper bits not zero");
   property p_val_ok;
      s_axi_rvalid && rd_addr_q[4:3] == 2'h1 |-> s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_val_ok: assert property (p_val_ok)
      else $error("value byte read refused");
   property p_cmp;
      compare_match |-> compare_value == $past({timer_one_high_byte, timer_one_low_byte});
   endproperty
   a_cmp: assert property (p_cmp)
      else $error("match without equal timer");
   property p_width;
      pulse_width_value != 10'h0 |-> pulse_width_value == compare_value[9:0]
         || pulse_width_value == {compare_value[15:8], compare_value[7:6]};
   endproperty
   a_width: assert property (p_width)
      else $error("width not taken from value bytes");
   property p_width_oe;
      pulse_width_value != 10'h0 |-> pin_output_enable;
   endproperty
   a_width_oe: assert property (p_width_oe)
      else $error("width without driven pin");
   property p_cap_quiet;
      capture_strobe |-> !pin_output_enable;
   endproperty
   a_cap_quiet: assert property (p_cap_quiet)
      else $error("capture while pin driven");
   property p_strobe_once;
      capture_strobe |=> !capture_strobe;
   endproperty
   a_strobe_once: assert property (p_strobe_once)
      else $error("capture strobe longer than one cycle");
endmodule // ccs_channel_monitor

bind ccs_channel ccs_channel_monitor ccs_channel_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .timer_one_low_byte(timer_one_low_byte), .timer_one_high_byte(timer_one_high_byte),
   .pulse_width_value(pulse_width_value), .compare_value(compare_value),
   .compare_match(compare_match), .capture_strobe(capture_strobe),
   .pin_output_enable(pin_output_enable), .irq(irq));
`default_nettype wire

/* File: sim/ccs_channel_test.sv */
// Self-checking bench for the capture channel over AXI4-Lite.
// Assumes the source model and checker files are compiled first.
`default_nettype none

// ************************************************************
// Bench top
// ************************************************************
module ccs_channel_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, compare_match, capture_strobe;
   logic        pin_output_enable, irq, tmr_hold, ev_lvl;
   logic [4:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, rv, rs, v, last;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [7:0]  timer_one_low_byte, timer_one_high_byte;
   logic [9:0]  pulse_width_value;
   logic [15:0] compare_value, tmr_load;
   logic [2:0]  ev_sel;
   logic [6:0]  ev_lines;
   int          fail_count, samples_checked, n;

   ccs_src_model ccs_src_model_inst (.clk_sys, .rst_n, .tmr_hold, .tmr_load, .ev_sel, .ev_lvl,
      .tmr_lo(timer_one_low_byte), .tmr_hi(timer_one_high_byte), .ev_lines);
   ccs_channel ccs_channel_inst (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_one_low_byte,
      .timer_one_high_byte, .channel_mapped_pin(ev_lines[0]),
      .comparator_one_output(ev_lines[1]), .comparator_two_output(ev_lines[2]),
      .numeric_oscillator_output(ev_lines[3]), .pin_change_event(ev_lines[4]),
      .logic_cell_one_out(ev_lines[5]), .logic_cell_two_out(ev_lines[6]),
      .pulse_width_value, .compare_value, .compare_match, .capture_strobe,
      .pin_output_enable, .irq);

   // Repeatable xorshift stream
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected width: left alignment drops low bits 5..0, right drops high bits 7..2
   function automatic logic [9:0] pw_exp(input logic f, input logic [7:0] h, input logic [7:0] l);
      return f ? {h, l[7:6]} : {h[1:0], l};
   endfunction

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask

   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1'b1;
      s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rs = {30'h0, s_axi_bresp};
      s_axi_bready <= 1'b0;
      cyc(2);
   endtask

   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      rs = {30'h0, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask

   task automatic summarize();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // 50 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // Watchdog far beyond the thousand or so cycles the run needs
   initial
   begin
      #400us;
      fail_count++;
      summarize();
   end

   initial
   begin
      seed = 32'd64; rst_n = 1'b0; s_axi_wstrb = 4'hf; s_axi_awaddr = 5'h00; s_axi_araddr = 5'h00;
      s_axi_wdata = 32'h0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; tmr_hold = 1'b0; tmr_load = 16'h0;
      ev_sel = 3'h0; ev_lvl = 1'b0;
      cyc(4);
      rst_n <= 1'b1;
      rd(5'h00, rv); chk(rv, 32'h0);
      rd(5'h04, rv); chk(rv, 32'h0);
      rd(5'h1c, rv); chk(rs, 32'h2); chk(rv, 32'h0);
      wr(5'h1c, 32'h5a);
      chk(rs, 32'h2);
      // Every source code; only the low three bits stick
      for (int i = 0; i < 8; i++)
      begin
         v = rnd();
         v[2:0] = i[2:0];
         wr(5'h04, v);
         chk(rs, 32'h0);
         rd(5'h04, rv);
         chk(rv, {29'h0, v[2:0]});
      end
      // A write with byte lane 0 off leaves the register as it was
      s_axi_wstrb <= 4'he;
      wr(5'h04, 32'h5);
      chk(rs, 32'h0);
      s_axi_wstrb <= 4'hf;
      rd(5'h04, rv);
      chk(rv, 32'h7);
      // Compare: each byte must match its own timer byte; bytes first so no unknown compares
      v = rnd();
      wr(5'h08, v);
      wr(5'h0c, v >> 8);
      wr(5'h00, 32'h88);
      rd(5'h08, rv); chk(rv, {24'h0, v[7:0]});
      tmr_hold <= 1'b1; tmr_load <= v[15:0]; cyc(4);
      chk(compare_value, v[15:0]); chk(compare_match, 1'b1);
      rd(5'h10, rv);
      chk(rv, 32'h2);
      tmr_load <= v[15:0] ^ 16'h0001; cyc(4); chk(compare_match, 1'b0);
      tmr_load <= v[15:0] ^ 16'h8000; cyc(4); chk(compare_match, 1'b0);
      // Width in both alignments from random bytes
      for (int f = 0; f < 2; f++)
      begin
         wr(5'h00, f ? 32'h9f : 32'h8f);
         repeat (4)
         begin
            v = rnd(); wr(5'h08, v); wr(5'h0c, v >> 8); cyc(3);
            chk(pulse_width_value, pw_exp(f[0], v[15:8], v[7:0]));
            rd(5'h0c, rv); chk(rv, {24'h0, v[15:8]});
         end
      end
      // Reset in mid-run releases the pin and clears control, not the value bytes
      chk(pin_output_enable, 1'b1);
      rst_n <= 1'b0; cyc(2); chk(pin_output_enable, 1'b0);
      rst_n <= 1'b1; rd(5'h00, rv); chk(rv, 32'h0);
      last = v;
      // Capture from each source with the interrupt raised, masked and cleared
      wr(5'h00, 32'h85); wr(5'h14, 32'h1);
      for (int i = 0; i < 8; i++)
      begin
         wr(5'h04, i); ev_sel <= i[2:0]; v = rnd(); tmr_load <= v[15:0]; cyc(4);
         ev_lvl <= 1'b1; n = 0;
         while (!capture_strobe && n < 12)
         begin
            @(posedge clk_sys);
            n++;
         end
         ev_lvl <= 1'b0; cyc(4);
         chk(n < 12, i < 7);
         if (i < 7) last = v;
         rd(5'h08, rv); chk(rv, {24'h0, last[7:0]});
         rd(5'h0c, rv); chk(rv, {24'h0, last[15:8]});
         rd(5'h10, rv);
         chk(rv, {31'h0, i < 7});
         if (i < 7)
         begin
            chk(irq, 1'b1); wr(5'h14, 32'h0); chk(irq, 1'b0);
            wr(5'h14, 32'h1); chk(irq, 1'b1); wr(5'h18, 32'h1); chk(irq, 1'b0);
         end
      end
      // Falling-edge mode ignores the rise and captures on the release
      wr(5'h00, 32'h84);
      wr(5'h04, 32'h0);
      ev_sel <= 3'h0;
      ev_lvl <= 1'b1;
      cyc(6);
      chk(irq, 1'b0);
      v = rnd();
      tmr_load <= v[15:0];
      ev_lvl <= 1'b0;
      cyc(6);
      chk(irq, 1'b1);
      rd(5'h08, rv);
      chk(rv, {24'h0, v[7:0]});
      rd(5'h0c, rv);
      chk(rv, {24'h0, v[15:8]});
      summarize();
   end
endmodule // ccs_channel_test
`default_nettype wire

/* File: sim/ccs_src_model.sv */
// Far-side model: the 16-bit timer and the seven capture event lines.
// Assumes the bench holds the timer while it fires an event, so the captured value is known.
`default_nettype none

// ************************************************************
// Timer and event sources
// ************************************************************
module ccs_src_model
(
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        tmr_hold,
   input  wire logic [15:0] tmr_load,
   input  wire logic [2:0]  ev_sel,
   input  wire logic        ev_lvl,
   output logic      [7:0]  tmr_lo,
   output logic      [7:0]  tmr_hi,
   output logic      [6:0]  ev_lines
);
   logic [15:0] cnt_q;

   // Free-running count unless held; hold makes the expected capture exact
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) cnt_q <= 16'h0000;
      else cnt_q <= tmr_hold ? tmr_load : cnt_q + 16'h0001;

   // Only the chosen line moves; code 111 drives no line at all
   assign ev_lines = ev_lvl ? (7'h01 << ev_sel) : 7'h00;
   assign tmr_lo   = cnt_q[7:0];
   assign tmr_hi   = cnt_q[15:8];
endmodule // ccs_src_model
`default_nettype wire
